// file: design/fsml_fault_latch.sv
// Fault status, report masking, latch control and thermal recovery.
`timescale 1ns/100ps
module fsml_fault_latch (
	// Clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST,
	// Analog detector levels, asynchronous
	input  wire fsml_pkg::fsml_fault_t FAULT_LIVE,
	// Register port from the control interface
	input  wire fsml_pkg::fsml_reg_req_t REG_REQ,
	output logic [7:0]                REG_RDATA,
	output logic                      REG_RVALID,
	// Pins and stage control
	output logic                      FAULT_N,
	output logic                      OUT_HIZ
);
	import fsml_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Write strobe for one offset, shared by every writable register
	function automatic logic wr_hit(input fsml_reg_req_t req, input logic [7:0] ofs);
		return req.wr && (req.addr == ofs);
	endfunction

	// ---------------------------------------------------------------
	// Synchronised detector levels
	// ---------------------------------------------------------------
	fsml_fault_t live;
	logic [FAULT_W-1:0] live_vec;

	fsml_sync #(
		.WIDTH   (FAULT_W)
	) fsml_sync_inst (
		.clk     (CLK),
		.rst     (RST),
		.async_in(FAULT_LIVE),
		.sync_out(live_vec)
	);

	assign live = fsml_fault_t'(live_vec);

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	logic [7:0] report_mask_q;
	logic [7:0] latch_cfg_q;
	logic [7:0] misc_control_q;
	logic [6:0] fault_clear_rsvd_q;
	logic       wr_hit_mask;
	logic       wr_hit_latch;
	logic       wr_hit_misc;
	logic       wr_hit_clear;
	logic       analog_clear;

	assign wr_hit_mask  = wr_hit(REG_REQ, FAULT_PIN_REPORT_MASK_OFS);
	assign wr_hit_latch = wr_hit(REG_REQ, FAULT_LATCH_AND_WARNING_MASK_OFS);
	assign wr_hit_misc  = wr_hit(REG_REQ, MISC_CONTROL_OFS);
	assign wr_hit_clear = wr_hit(REG_REQ, FAULT_CLEAR_OFS);
	// Self-clearing: acts only in the cycle of the write
	assign analog_clear = wr_hit_clear && REG_REQ.wdata[ANALOG_FAULT_CLEAR_BIT];

	// Report mask register
	always_ff @(posedge CLK) begin
		if (RST) begin
			report_mask_q <= REPORT_MASK_RST;
		end else if (wr_hit_mask) begin
			report_mask_q <= REG_REQ.wdata;
		end
	end

	// Latch enables and warning mask; reserved bits store as written
	always_ff @(posedge CLK) begin
		if (RST) begin
			latch_cfg_q <= LATCH_CFG_RST;
		end else if (wr_hit_latch) begin
			latch_cfg_q <= REG_REQ.wdata;
		end
	end

	// Miscellaneous control, holds the auto-recovery enable
	always_ff @(posedge CLK) begin
		if (RST) begin
			misc_control_q <= MISC_CONTROL_RST;
		end else if (wr_hit_misc) begin
			misc_control_q <= REG_REQ.wdata;
		end
	end

	// Reserved low bits of the clear register are plain storage
	always_ff @(posedge CLK) begin
		if (RST) begin
			fault_clear_rsvd_q <= FAULT_CLEAR_RST[6:0];
		end else if (wr_hit_clear) begin
			fault_clear_rsvd_q <= REG_REQ.wdata[6:0];
		end
	end

	logic auto_rec_en;
	logic clk_latch_en;
	logic ts_latch_en;
	logic ow_latch_en;

	assign auto_rec_en  = misc_control_q[THERMAL_AUTO_RECOVERY_ENABLE_BIT];
	assign clk_latch_en = latch_cfg_q[CLOCK_ERROR_LATCH_ENABLE_BIT];
	assign ts_latch_en  = latch_cfg_q[THERMAL_SHUTDOWN_LATCH_ENABLE_BIT];
	assign ow_latch_en  = latch_cfg_q[OVERTEMP_WARNING_LATCH_ENABLE_BIT];

	// ---------------------------------------------------------------
	// Thermal shutdown flag
	// ---------------------------------------------------------------
	// Armed goes low on a clear while hot and only returns once the die cools,
	// so a persisting condition cannot re-raise the flag.
	logic ts_prev_q;
	logic ts_armed_q;
	logic ts_rise;
	logic thermal_shutdown_flag_q;

	assign ts_rise = live.thermal_shutdown && !ts_prev_q;

	// Edge history of the shutdown condition
	always_ff @(posedge CLK) begin
		if (RST) begin
			ts_prev_q <= 1'b0;
		end else begin
			ts_prev_q <= live.thermal_shutdown;
		end
	end

	// Arming tracks a cool-down after a clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			ts_armed_q <= 1'b1;
		end else if (!live.thermal_shutdown) begin
			ts_armed_q <= 1'b1;
		end else if (analog_clear) begin
			ts_armed_q <= 1'b0;
		end
	end

	// Latched mode: fresh edge sets, clear drops; edge wins over clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			thermal_shutdown_flag_q <= 1'b0;
		end else if (ts_latch_en) begin
			if (ts_rise) begin
				thermal_shutdown_flag_q <= 1'b1;
			end else if (analog_clear) begin
				thermal_shutdown_flag_q <= 1'b0;
			end
		end else begin
			// Follows the condition, still held off after a clear
			thermal_shutdown_flag_q <= live.thermal_shutdown && ts_armed_q
				&& !(analog_clear && !ts_rise);
		end
	end

	// ---------------------------------------------------------------
	// Output stage high impedance
	// ---------------------------------------------------------------
	// Released by a clear even when still hot, which risks the stage;
	// auto-recovery is the safer path.
	always_ff @(posedge CLK) begin
		if (RST) begin
			OUT_HIZ <= 1'b0;
		end else if (ts_rise) begin
			OUT_HIZ <= 1'b1;
		end else if (analog_clear) begin
			OUT_HIZ <= 1'b0;
		end else if (auto_rec_en && !live.thermal_shutdown) begin
			OUT_HIZ <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Over-temperature warning flag
	// ---------------------------------------------------------------
	logic overtemp_warning_flag_q;

	// Sticky when latched, set wins over a same-cycle clear
	always_ff @(posedge CLK) begin
		if (RST) begin
			overtemp_warning_flag_q <= 1'b0;
		end else if (ow_latch_en) begin
			if (live.overtemp_warning) begin
				overtemp_warning_flag_q <= 1'b1;
			end else if (analog_clear) begin
				overtemp_warning_flag_q <= 1'b0;
			end
		end else begin
			overtemp_warning_flag_q <= live.overtemp_warning;
		end
	end

	// ---------------------------------------------------------------
	// Clock error indication
	// ---------------------------------------------------------------
	logic clock_error_ind_q;

	// Same latch policy as the warning
	always_ff @(posedge CLK) begin
		if (RST) begin
			clock_error_ind_q <= 1'b0;
		end else if (clk_latch_en) begin
			if (live.clock_error) begin
				clock_error_ind_q <= 1'b1;
			end else if (analog_clear) begin
				clock_error_ind_q <= 1'b0;
			end
		end else begin
			clock_error_ind_q <= live.clock_error;
		end
	end

	// ---------------------------------------------------------------
	// Fault pin
	// ---------------------------------------------------------------
	// Supply, DC and over-current faults are latched in their own
	// status logic elsewhere; here they report as live levels.
	logic report_any;

	always_comb begin
		report_any = 1'b0;
		if (thermal_shutdown_flag_q && !report_mask_q[THERMAL_SHUTDOWN_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (clock_error_ind_q && !report_mask_q[CLOCK_ERROR_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (live.supply_undervoltage
			&& !report_mask_q[SUPPLY_UNDERVOLTAGE_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (live.supply_overvoltage && !report_mask_q[SUPPLY_OVERVOLTAGE_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (live.dc_offset && !report_mask_q[DC_OFFSET_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (live.overcurrent && !report_mask_q[OVERCURRENT_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
		if (overtemp_warning_flag_q && !latch_cfg_q[OVERTEMP_WARNING_REPORT_MASK_BIT]) begin
			report_any = 1'b1;
		end
	end

	// Active low pin, registered
	always_ff @(posedge CLK) begin
		if (RST) begin
			FAULT_N <= 1'b1;
		end else begin
			FAULT_N <= !report_any;
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;

	// Unmapped offsets and reserved status bits read zero
	always_comb begin
		rd_mux = 8'h00;
		case (REG_REQ.addr)
			THERMAL_SHUTDOWN_STATUS_OFS: begin
				rd_mux[THERMAL_SHUTDOWN_FLAG_BIT] = thermal_shutdown_flag_q;
			end
			THERMAL_WARNING_STATUS_OFS: begin
				rd_mux[OVERTEMP_WARNING_FLAG_BIT] = overtemp_warning_flag_q;
			end
			FAULT_PIN_REPORT_MASK_OFS: begin
				rd_mux = report_mask_q;
			end
			FAULT_LATCH_AND_WARNING_MASK_OFS: begin
				rd_mux = latch_cfg_q;
			end
			MISC_CONTROL_OFS: begin
				rd_mux = misc_control_q;
			end
			FAULT_CLEAR_OFS: begin
				rd_mux = {1'b0, fault_clear_rsvd_q};
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// One-cycle read answer
	always_ff @(posedge CLK) begin
		if (RST) begin
			REG_RDATA  <= 8'h00;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_REQ.rd;
			if (REG_REQ.rd) begin
				REG_RDATA <= rd_mux;
			end
		end
	end

endmodule

// file: design/fsml_pkg.sv
// Package for the fault status, report mask and latch control block.
package fsml_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] THERMAL_SHUTDOWN_STATUS_OFS      = 8'h72;
	localparam logic [7:0] THERMAL_WARNING_STATUS_OFS       = 8'h73;
	localparam logic [7:0] FAULT_PIN_REPORT_MASK_OFS        = 8'h74;
	localparam logic [7:0] FAULT_LATCH_AND_WARNING_MASK_OFS = 8'h75;
	localparam logic [7:0] MISC_CONTROL_OFS                 = 8'h76;
	localparam logic [7:0] FAULT_CLEAR_OFS                  = 8'h78;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] REPORT_MASK_RST  = 8'h00;
	localparam logic [7:0] LATCH_CFG_RST    = 8'hf8;
	localparam logic [7:0] MISC_CONTROL_RST = 8'h00;
	localparam logic [7:0] FAULT_CLEAR_RST  = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int THERMAL_SHUTDOWN_FLAG_BIT          = 0;
	localparam int OVERTEMP_WARNING_FLAG_BIT          = 3;
	localparam int THERMAL_SHUTDOWN_REPORT_MASK_BIT   = 7;
	localparam int CLOCK_ERROR_REPORT_MASK_BIT        = 4;
	localparam int SUPPLY_UNDERVOLTAGE_REPORT_MASK_BIT = 3;
	localparam int SUPPLY_OVERVOLTAGE_REPORT_MASK_BIT = 2;
	localparam int DC_OFFSET_REPORT_MASK_BIT          = 1;
	localparam int OVERCURRENT_REPORT_MASK_BIT        = 0;
	localparam int CLOCK_ERROR_LATCH_ENABLE_BIT       = 5;
	localparam int THERMAL_SHUTDOWN_LATCH_ENABLE_BIT  = 4;
	localparam int OVERTEMP_WARNING_LATCH_ENABLE_BIT  = 3;
	localparam int OVERTEMP_WARNING_REPORT_MASK_BIT   = 2;
	localparam int THERMAL_AUTO_RECOVERY_ENABLE_BIT   = 4;
	localparam int ANALOG_FAULT_CLEAR_BIT             = 7;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	// Live conditions from the analog detectors
	typedef struct packed {
		logic thermal_shutdown;
		logic overtemp_warning;
		logic clock_error;
		logic supply_undervoltage;
		logic supply_overvoltage;
		logic dc_offset;
		logic overcurrent;
	} fsml_fault_t;

	localparam int FAULT_W = $bits(fsml_fault_t);

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fsml_reg_req_t;

endpackage

// file: design/fsml_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/100ps
module fsml_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// file: tb/fsml_fault_latch_properties.sv
// Port checker for the fault status and latch block, bound to its top.
`timescale 1ns/100ps
module fsml_fault_latch_properties
	import fsml_pkg::*;
(
	// Clock and reset
	input wire logic                   CLK,
	input wire logic                   RST,
	// Detector levels and register port
	input wire fsml_pkg::fsml_fault_t  FAULT_LIVE,
	input wire fsml_pkg::fsml_reg_req_t REG_REQ,
	input wire logic [7:0]             REG_RDATA,
	input wire logic                   REG_RVALID,
	// Pins
	input wire logic                   FAULT_N,
	input wire logic                   OUT_HIZ
);
	// ---------------------------------------------------------------
	// Shadow of the mask registers
	// ---------------------------------------------------------------
	logic [7:0] msk_q;
	logic [7:0] cfg_q;
	logic       clr;
	logic       all_msk;
	logic       mapped;

	// Tracks writes so pin checks know which sources are silenced
	always_ff @(posedge CLK) begin
		if (RST) begin
			msk_q <= 8'h00;
			cfg_q <= 8'hf8;
		end else if (REG_REQ.wr) begin
			if (REG_REQ.addr == 8'h74)
				msk_q <= REG_REQ.wdata;
			if (REG_REQ.addr == 8'h75)
				cfg_q <= REG_REQ.wdata;
		end
	end

	// Decodes used by several properties
	assign clr     = REG_REQ.wr && REG_REQ.addr == 8'h78 && REG_REQ.wdata[7];
	assign all_msk = msk_q[7] && (&msk_q[4:0]) && cfg_q[2];
	assign mapped  = REG_REQ.addr inside {8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h78};

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	a_read_answered: assert property (REG_REQ.rd |=> REG_RVALID)
		else $error("read got no answer");
	a_answer_has_read: assert property (REG_RVALID |-> $past(REG_REQ.rd))
		else $error("answer without a read");
	a_rdata_holds: assert property (!REG_REQ.rd |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (REG_REQ.rd && !mapped |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_status_reserved: assert property ((REG_REQ.rd && REG_REQ.addr inside {8'h72, 8'h73})
		|=> (REG_RDATA & 8'hf6) == 8'h00)
		else $error("status reserved bits set");
	a_oc_reported: assert property ((FAULT_LIVE.overcurrent && !msk_q[0])[*5] |-> !FAULT_N)
		else $error("unmasked over-current not on pin");
	a_all_masked_quiet: assert property (all_msk[*3] |-> FAULT_N)
		else $error("pin low with every source masked");
	a_hiz_on_shutdown: assert property (($rose(FAULT_LIVE.thermal_shutdown) && !REG_REQ.wr)
		##1 (FAULT_LIVE.thermal_shutdown && !REG_REQ.wr)[*3] |-> OUT_HIZ)
		else $error("shutdown did not raise high impedance");
	a_clear_while_hot: assert property (FAULT_LIVE.thermal_shutdown[*6] ##0 clr
		##1 (FAULT_LIVE.thermal_shutdown && !REG_REQ.wr)[*3] |-> !OUT_HIZ)
		else $error("clear while hot kept high impedance");

	// Main scenarios reached
	c_clear_hot: cover property (clr && FAULT_LIVE.thermal_shutdown);
	c_unmapped: cover property (REG_REQ.rd && !mapped);
	c_hiz_drop: cover property ($fell(OUT_HIZ));
endmodule

bind fsml_fault_latch fsml_fault_latch_properties fsml_fault_latch_properties_inst (
	.CLK(CLK), .RST(RST), .FAULT_LIVE(FAULT_LIVE), .REG_REQ(REG_REQ),
	.REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FAULT_N(FAULT_N), .OUT_HIZ(OUT_HIZ));

// file: tb/fsml_fault_latch_tb.sv
// Self-checking bench for the fault status and latch block.
`timescale 1ns/100ps
module fsml_fault_latch_tb;
	import fsml_pkg::*;
	// ---------------------------------------------------------------
	// Signals and expectations
	// ---------------------------------------------------------------
	localparam fsml_fault_t NONE = 7'h00;
	localparam fsml_fault_t CLKF = 7'h10;
	localparam fsml_fault_t WARN = 7'h20;
	localparam fsml_fault_t HOT  = 7'h40;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	fsml_fault_t   live = '0;
	fsml_reg_req_t req = '0;
	logic [7:0]    rdata;
	logic          rvalid;
	logic          fault_n;
	logic          out_hiz;
	logic [9:0]    exp_q[$];
	logic [9:0]    cur;
	logic [7:0]    msk;
	int            n_fail = 0;
	int            total_checks = 0;
	logic [7:0]    ofs[6] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77};
	logic [7:0]    rv[6] = '{8'h00, 8'h00, 8'h00, 8'hf8, 8'h00, 8'h00};

	// 25 MHz clock
	always #20 clk = ~clk;

	fsml_fault_latch fsml_fault_latch_inst (
		.CLK(clk), .RST(rst), .FAULT_LIVE(live), .REG_REQ(req),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .FAULT_N(fault_n), .OUT_HIZ(out_hiz));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cmp1(input string nm, input logic e, input logic s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", nm, e, s);
		end
	endtask

	// Request held one edge, then a spare edge so req is never driven twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask

	// Notes data and pin levels expected when the answer arrives
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic fn, input logic hz);
		exp_q.push_back({d, fn, hz});
		req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask

	// Six edges cover the two-flop sync plus the flag and pin stages
	task automatic hold(input fsml_fault_t f);
		live <= f;
		repeat (6) @(posedge clk);
	endtask

	// ---------------------------------------------------------------
	// Answer monitor and watchdog
	// ---------------------------------------------------------------
	always @(negedge clk) begin
		if (rvalid === 1'b1 && exp_q.size() > 0) begin
			cur = exp_q.pop_front();
			cmp8("rdata", cur[9:2], rdata);
			cmp1("fault_n", cur[1], fault_n);
			cmp1("out_hiz", cur[0], out_hiz);
		end
	end

	// Whole sequence needs well under 1000 cycles
	initial begin
		#(40 * 4000);
		n_fail++;
		$display("[FAIL] watchdog expected done seen timeout");
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h257a));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(ofs[i], rv[i], 1'b1, 1'b0);
		wr(8'h72, 8'hff);
		rd(8'h72, 8'h00, 1'b1, 1'b0);
		msk = 8'h00;
		for (int i = 0; i < 5; i++) begin
			hold(fsml_fault_t'(7'(1 << i)));
			rd(8'h74, msk, 1'b0, 1'b0);
			msk = msk | 8'(1 << i) | (8'($urandom) & 8'h60);
			wr(8'h74, msk);
			hold(live);
			rd(8'h74, msk, 1'b1, 1'b0);
			hold(NONE);
			wr(8'h78, 8'h80);
		end
		wr(8'h74, 8'h00);
		hold(CLKF);
		hold(NONE);
		rd(8'h74, 8'h00, 1'b0, 1'b0);
		wr(8'h78, 8'h80);
		hold(WARN);
		rd(8'h73, 8'h08, 1'b0, 1'b0);
		hold(NONE);
		rd(8'h73, 8'h08, 1'b0, 1'b0);
		wr(8'h78, 8'h80);
		hold(NONE);
		rd(8'h73, 8'h00, 1'b1, 1'b0);
		wr(8'h75, 8'hf0);
		hold(WARN);
		rd(8'h73, 8'h08, 1'b0, 1'b0);
		hold(NONE);
		rd(8'h73, 8'h00, 1'b1, 1'b0);
		wr(8'h75, 8'hf4);
		wr(8'h74, 8'h9f);
		hold(WARN);
		rd(8'h75, 8'hf4, 1'b1, 1'b0);
		hold(NONE);
		wr(8'h75, 8'hf8);
		wr(8'h74, 8'h00);
		hold(HOT);
		rd(8'h72, 8'h01, 1'b0, 1'b1);
		wr(8'h74, 8'h80);
		hold(HOT);
		rd(8'h72, 8'h01, 1'b1, 1'b1);
		wr(8'h74, 8'h00);
		wr(8'h78, 8'h80);
		hold(HOT);
		rd(8'h72, 8'h00, 1'b1, 1'b0);
		hold(NONE);
		hold(HOT);
		rd(8'h72, 8'h01, 1'b0, 1'b1);
		wr(8'h76, 8'h10);
		hold(NONE);
		rd(8'h72, 8'h01, 1'b0, 1'b0);
		wr(8'h78, 8'h80);
		wr(8'h75, 8'he8);
		hold(HOT);
		rd(8'h72, 8'h01, 1'b0, 1'b1);
		hold(NONE);
		rd(8'h72, 8'h00, 1'b1, 1'b0);
		// Reserved clear bits store; bit 7 never reads back
		msk = 8'($urandom) & 8'h7f;
		wr(8'h78, msk);
		rd(8'h78, msk, 1'b1, 1'b0);
		// Mid-run reset returns every register to its reset value
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			rd(ofs[i], rv[i], 1'b1, 1'b0);
		rd(8'h78, 8'h00, 1'b1, 1'b0);
		repeat (4) @(posedge clk);
		cmp8("pending answers", 8'h00, 8'(exp_q.size()));
		stop_test();
	end
endmodule
